// *** design/acc_map.svh ***
// Register offsets, field positions and reset values for the comparator
// control block. Assumes a byte-wide register file with 12-bit addresses.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ==========================================================
// Register offsets
`define ACC_CONFIG_OFF 12'hF90
`define ACC_STATUS_OFF 12'hF91
`define ACC_MASK_OFF 12'hF92
`define ACC_POWER_OFF 12'hF93

// ==========================================================
// Control register fields
`define ACC_POS_SEL_BIT 7
`define ACC_NEG_SEL_BIT 6
`define ACC_LVL_HI 5
`define ACC_LVL_LO 2
`define ACC_LVL_RESET 4'h5
`define ACC_LVL_MAX 4'h9
`define ACC_CONFIG_RESET 8'h14

// ==========================================================
// Status and mask fields
`define ACC_RISE_BIT 0
`define ACC_FALL_BIT 1
`define ACC_EVT_W 2

`endif

// *** design/acc_pkg.sv ***
// Types shared by the comparator control block.
// Assumes the map header supplies all numeric constants.
package acc_pkg;

  // ==========================================================
  // Synchroniser state, one-hot
  typedef enum logic [2:0] {
    ACC_SYNC_IDLE = 3'b001,
    ACC_SYNC_FILL = 3'b010,
    ACC_SYNC_RUN = 3'b100
  } acc_sync_type;

endpackage

// *** design/acc_comparator_control.sv ***
// Comparator control: configuration register, input steering, reference
// level, output synchroniser and interrupt logic.
// Assumes a single-cycle register port and an analog comparator outside.
//
// Overview of operation
// - Bit 7 picks pin or temperature sensor
// - Bit 6 enables reference onto negative input
// - Four-bit code sets reference, 0.2 V steps
// - Reset: selects clear, level code 0101
// - Low two bits write ignored, read zero
// - Result drives interrupt and pin mux
// - Separate power bit powers comparator down
// - Reference independent from converter reference
// - Single control register at F90h; here status, mask and power sit at F91h-F93h too
`timescale 1ns/1ps
`include "acc_map.svh"

module acc_comparator_control #(
  parameter int LVL_W = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic comparator_raw,
  output logic positive_input_select,
  output logic negative_input_select,
  output logic [LVL_W-1:0] reference_level,
  output logic comparator_powered_down,
  output logic comparator_result,
  output logic comparator_irq
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic pos_sel;
    logic neg_sel;
    logic [LVL_W-1:0] lvl;
    logic pwr_down;
    logic [`ACC_EVT_W-1:0] status;
    logic [`ACC_EVT_W-1:0] mask;
    logic sync1;
    logic sync2;
    logic res;
    acc_pkg::acc_sync_type sst;
    logic [7:0] rdata;
    logic irq;
  } acc_state_type;

  acc_state_type st_r;
  acc_state_type st_nxt;

  // Address match, used for reads and writes alike
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic [`ACC_EVT_W-1:0] evt;
  logic [`ACC_EVT_W-1:0] w1c;
  logic [`ACC_EVT_W-1:0] new_status;

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Second flop alone reads the first; edge logic uses later stages
    st_nxt.sync1 = comparator_raw;
    st_nxt.sync2 = st_r.sync1;
    // Powered-down comparator output is meaningless, so hold result
    if (!st_r.pwr_down) begin
      st_nxt.res = st_r.sync2;
    end
    // Idle and fill states mask the first two result updates after power-up; after reset sync2 and res are zero in both
    case (st_r.sst)
      acc_pkg::ACC_SYNC_IDLE: begin
        if (!st_r.pwr_down) begin
          st_nxt.sst = acc_pkg::ACC_SYNC_FILL;
        end
      end
      acc_pkg::ACC_SYNC_FILL: begin
        st_nxt.sst = acc_pkg::ACC_SYNC_RUN;
      end
      acc_pkg::ACC_SYNC_RUN: begin
        if (st_r.pwr_down) begin
          st_nxt.sst = acc_pkg::ACC_SYNC_IDLE;
        end
      end
      default: st_nxt.sst = acc_pkg::ACC_SYNC_IDLE;
    endcase
    evt = '0;
    if (st_r.sst == acc_pkg::ACC_SYNC_RUN && !st_r.pwr_down) begin
      evt[`ACC_RISE_BIT] = st_r.sync2 & ~st_r.res;
      evt[`ACC_FALL_BIT] = ~st_r.sync2 & st_r.res;
    end
    // Register writes
    w1c = '0;
    if (reg_wr) begin
      if (hit(reg_addr, `ACC_CONFIG_OFF)) begin
        st_nxt.pos_sel = reg_wdata[`ACC_POS_SEL_BIT];
        st_nxt.neg_sel = reg_wdata[`ACC_NEG_SEL_BIT];
        st_nxt.lvl = reg_wdata[`ACC_LVL_HI:`ACC_LVL_LO];
      end
      if (hit(reg_addr, `ACC_STATUS_OFF)) begin
        w1c = reg_wdata[`ACC_EVT_W-1:0];
      end
      if (hit(reg_addr, `ACC_MASK_OFF)) begin
        st_nxt.mask = reg_wdata[`ACC_EVT_W-1:0];
      end
      if (hit(reg_addr, `ACC_POWER_OFF)) begin
        st_nxt.pwr_down = reg_wdata[0];
      end
    end
    // Set wins over a clear landing in the same cycle
    new_status = (st_r.status & ~w1c) | evt;
    st_nxt.status = new_status;
    st_nxt.irq = |(new_status & st_nxt.mask);
    // Read data stands one cycle after the strobe only
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `ACC_CONFIG_OFF)) begin
        // Low two bits always read back as zero
        st_nxt.rdata = {st_r.pos_sel, st_r.neg_sel, st_r.lvl, 2'b00};
      end else if (hit(reg_addr, `ACC_STATUS_OFF)) begin
        st_nxt.rdata = {6'h00, st_r.status};
      end else if (hit(reg_addr, `ACC_MASK_OFF)) begin
        st_nxt.rdata = {6'h00, st_r.mask};
      end else if (hit(reg_addr, `ACC_POWER_OFF)) begin
        st_nxt.rdata = {7'h00, st_r.pwr_down};
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.pos_sel <= 1'b0;
      st_r.neg_sel <= 1'b0;
      st_r.lvl <= `ACC_LVL_RESET;
      st_r.pwr_down <= 1'b0;
      st_r.status <= '0;
      st_r.mask <= '0;
      st_r.sync1 <= 1'b0;
      st_r.sync2 <= 1'b0;
      st_r.res <= 1'b0;
      st_r.sst <= acc_pkg::ACC_SYNC_IDLE;
      st_r.rdata <= 8'h00;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  // Reference field goes only to the comparator ladder, never to the
  // converter reference logic
  assign positive_input_select = st_r.pos_sel;
  assign negative_input_select = st_r.neg_sel;
  assign reference_level = st_r.lvl;
  assign comparator_powered_down = st_r.pwr_down;
  assign comparator_result = st_r.res;
  assign comparator_irq = st_r.irq;
  assign reg_rdata = st_r.rdata;

  // ==========================================================
  // Checks
  // Register accesses that several checks start from
  sequence s_cfg_write;
    reg_wr && reg_addr == `ACC_CONFIG_OFF;
  endsequence

  sequence s_cfg_read;
    reg_rd && !reg_wr && reg_addr == `ACC_CONFIG_OFF;
  endsequence

  sequence s_stat_write;
    reg_wr && reg_addr == `ACC_STATUS_OFF;
  endsequence

  sequence s_pwr_write;
    reg_wr && reg_addr == `ACC_POWER_OFF;
  endsequence

  // Edge logic live: synchroniser running and comparator powered
  sequence s_armed;
    st_r.sst == acc_pkg::ACC_SYNC_RUN && !comparator_powered_down;
  endsequence

  // Select bits land one cycle after their write
  a_cfg_write: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_cfg_write |=>
    positive_input_select == $past(reg_wdata[`ACC_POS_SEL_BIT]) &&
    negative_input_select == $past(reg_wdata[`ACC_NEG_SEL_BIT]))
    else $error("config select bits not stored");

  // Level code lands with the same write
  a_lvl_write: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_cfg_write |=>
    reference_level == $past(reg_wdata[`ACC_LVL_HI:`ACC_LVL_LO]))
    else $error("reference level not stored");

  // Reserved pair never reads back as ones
  a_rsvd_zero: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_cfg_read |=> reg_rdata[1:0] == 2'b00)
    else $error("reserved bits read nonzero");

  // Readback shows the settings held at the strobe
  a_cfg_read: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_cfg_read |=>
    reg_rdata[7:2] == $past({positive_input_select, negative_input_select,
      reference_level}))
    else $error("config readback wrong");

  // Addresses outside the map read as zero
  a_unmapped_read: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    reg_rd && reg_addr != `ACC_CONFIG_OFF && reg_addr != `ACC_STATUS_OFF &&
    reg_addr != `ACC_MASK_OFF && reg_addr != `ACC_POWER_OFF |=>
    reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  // Read data stands only in the cycle after a strobe
  a_rdata_idle: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present without a strobe");

  // Three flops from pin to result while powered
  a_sync_lat: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    !comparator_powered_down [*4] |->
    comparator_result == $past(comparator_raw, 3))
    else $error("result not three cycles behind input");

  // Second stage copies the first, nothing else in between
  a_sync_chain: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    1'b1 |=> st_r.sync2 == $past(st_r.sync1))
    else $error("synchroniser stage skipped");

  // Guard state stays one-hot, else edges could be lost
  a_sst_onehot: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    $onehot(st_r.sst))
    else $error("synchroniser state not one-hot");

  // Level interrupt tracks the registered status and mask
  a_irq_level: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    comparator_irq == |(st_r.status & st_r.mask))
    else $error("interrupt does not follow status and mask");

  // A rising result while armed leaves the rise flag set
  a_rise_flag: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_armed ##1 $rose(comparator_result) |-> st_r.status[`ACC_RISE_BIT])
    else $error("rising result not flagged");

  // A falling result while armed leaves the fall flag set
  a_fall_flag: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_armed ##1 $fell(comparator_result) |-> st_r.status[`ACC_FALL_BIT])
    else $error("falling result not flagged");

  // A rise event always lands, even against a clear
  a_set_wins: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    evt[`ACC_RISE_BIT] |=> st_r.status[`ACC_RISE_BIT])
    else $error("rise event lost");

  // Writing one clears the flag when no event competes
  a_w1c_clear: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_stat_write ##0 reg_wdata[`ACC_RISE_BIT] && !evt[`ACC_RISE_BIT] |=>
    !st_r.status[`ACC_RISE_BIT])
    else $error("rise flag not cleared");

  // Power bit lands one cycle after its write
  a_pwr_write: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    s_pwr_write |=> comparator_powered_down == $past(reg_wdata[0]))
    else $error("power bit not stored");

  // Frozen result while the comparator is off
  a_pwr_hold: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    comparator_powered_down [*2] |-> $stable(comparator_result))
    else $error("result moved while powered down");

  // No new flags from a powered-down comparator
  a_pwr_no_evt: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    comparator_powered_down |=>
    (st_r.status & ~$past(st_r.status)) == '0)
    else $error("event flagged while powered down");

  // Level code comes out of reset at its default
  a_reset_val: assert property (@(posedge ref_clk)
    $rose(arst_n) |-> reference_level == `ACC_LVL_RESET || $past(reg_wr))
    else $error("reference level reset value wrong");

  // Both selects come out of reset clear
  a_sel_reset: assert property (@(posedge ref_clk)
    $rose(arst_n) |->
    (!positive_input_select && !negative_input_select) || $past(reg_wr))
    else $error("input selects not clear after reset");

  // Only its own write moves the level code
  a_ref_indep: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    !(reg_wr && reg_addr == `ACC_CONFIG_OFF) |=> $stable(reference_level))
    else $error("reference level changed without its write");

endmodule

// *** testbench/acc_analog_model.sv ***
// Behavioural analog front end: pins, sensor, reference and comparator.
// Assumes the bench supplies input levels in millivolts.
`timescale 1ns/1ps

module acc_analog_model (
  input wire logic ref_clk,
  input wire logic positive_input_select,
  input wire logic negative_input_select,
  input wire logic [3:0] reference_level,
  input wire logic comparator_powered_down,
  input int pin_p_mv,
  input int pin_n_mv,
  input int temp_mv,
  output logic comparator_raw = 1'b0
);
  int pos_mv;
  int neg_mv;

  // Input steering, reference at 200 mV per code step
  always_comb begin
    pos_mv = positive_input_select ? temp_mv : pin_p_mv;
    neg_mv = negative_input_select ? 200 * int'(reference_level)
      : pin_n_mv;
  end

  // Unpowered output carries no meaning, so it wanders every cycle
  always @(posedge ref_clk) begin
    if (comparator_powered_down) begin
      comparator_raw <= ~comparator_raw;
    end else begin
      comparator_raw <= (pos_mv > neg_mv);
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the comparator control block.
// Assumes the analog model drives the raw comparator output.
`timescale 1ns/1ps
`include "acc_map.svh"

module tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic raw, psel, nsel, pdn, res, irq;
  logic [3:0] lvl;
  int pin_p = 0;
  int pin_n = 0;
  int temp = 0;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h9703_056e;
  logic [7:0] d;
  logic [7:0] v;

  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;

  acc_comparator_control i_acc_comparator_control (.ref_clk(ref_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_raw(raw), .positive_input_select(psel),
    .negative_input_select(nsel), .reference_level(lvl),
    .comparator_powered_down(pdn), .comparator_result(res),
    .comparator_irq(irq));

  acc_analog_model i_acc_analog_model (.ref_clk(ref_clk),
    .positive_input_select(psel), .negative_input_select(nsel),
    .reference_level(lvl), .comparator_powered_down(pdn),
    .pin_p_mv(pin_p), .pin_n_mv(pin_n), .temp_mv(temp),
    .comparator_raw(raw));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Low two bits never stick
  function automatic logic [7:0] cfg(input logic [7:0] w);
    return {w[7:2], 2'b00};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] r);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask

  // Bounded wait on the synchronised result
  task automatic wait_res(input logic e);
    int n;
    n = 0;
    while (res !== e && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (res !== e) begin
      chk({7'h00, res}, {7'h00, e});
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`ACC_CONFIG_OFF, v);
    chk(v, 8'h14);
    chk({psel, nsel, lvl, 2'b00}, 8'h14);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = {seed[7:2], 2'b00};
      wr(`ACC_CONFIG_OFF, d);
      rd(`ACC_CONFIG_OFF, v);
      chk(v, cfg(d));
      chk({psel, nsel, lvl, 2'b00}, cfg(d));
    end
    wr(12'h0F94, 8'hFF);
    rd(12'h0F94, v);
    chk(v, 8'h00);
    rd(`ACC_CONFIG_OFF, v);
    chk(v, cfg(d));
    // Reference at 1.0 V, quiet the flags before arming
    wr(`ACC_CONFIG_OFF, 8'h54);
    repeat (6) @(posedge ref_clk);
    wr(`ACC_STATUS_OFF, 8'h03);
    wr(`ACC_MASK_OFF, 8'h01);
    pin_p <= 1100;
    wait_res(1'b1);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h01);
    // Sensor below reference gives a masked falling event
    wr(`ACC_CONFIG_OFF, 8'hD4);
    temp <= 700;
    wait_res(1'b0);
    rd(`ACC_STATUS_OFF, v);
    chk(v, 8'h03);
    wr(`ACC_STATUS_OFF, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    // Powered down: result frozen, no new events
    wr(`ACC_POWER_OFF, 8'h01);
    temp <= 1500;
    repeat (8) @(posedge ref_clk);
    chk({6'h00, pdn, res}, 8'h02);
    rd(`ACC_STATUS_OFF, v);
    chk(v, 8'h02);
    wr(`ACC_POWER_OFF, 8'h00);
    // Let the wandering output drain out of the synchroniser
    repeat (6) @(posedge ref_clk);
    wait_res(1'b1);
    tally_and_finish();
  end
endmodule
